// *** bmsa_pkg.sv ***
// Package for the block move, search and 8-bit ALU datapath
package bmsa_pkg;
  // Operation codes presented on the command port
  typedef enum logic [3:0] {
    BMSA_OP_ADD = 4'h0,
    BMSA_OP_ADC = 4'h1,
    BMSA_OP_SUB = 4'h2,
    BMSA_OP_SBB = 4'h3,
    BMSA_OP_AND = 4'h4,
    BMSA_OP_OR = 4'h5,
    BMSA_OP_XOR = 4'h6,
    BMSA_OP_CMP_UP = 4'h7,
    BMSA_OP_CMP_DN = 4'h8,
    BMSA_OP_CMP_RUP = 4'h9,
    BMSA_OP_CMP_RDN = 4'ha,
    BMSA_OP_CPY_UP = 4'hb,
    BMSA_OP_CPY_DN = 4'hc,
    BMSA_OP_CPY_RUP = 4'hd,
    BMSA_OP_CPY_RDN = 4'he,
    BMSA_OP_INTA = 4'hf
  } bmsa_op_t;
  // Source operand selection
  typedef enum logic [1:0] {
    BMSA_SRC_REG = 2'h0,
    BMSA_SRC_IMM = 2'h1,
    BMSA_SRC_PTR = 2'h2,
    BMSA_SRC_IDX = 2'h3
  } bmsa_src_t;
  // Command bundle
  typedef struct packed {
    bmsa_op_t op;
    bmsa_src_t src;
    logic idx_sel;
    logic [2:0] reg_sel;
    logic [7:0] imm;
    logic [7:0] disp;
  } bmsa_cmd_t;
  // Bus control bundle, active high inside the block
  typedef struct packed {
    logic rd;
    logic wr;
    logic mreq;
    logic io_request;
    logic fetch;
  } bmsa_bus_t;
  // Machine states, Gray from idle through write to done
  typedef enum logic [2:0] {
    BMSA_IDLE = 3'h0,
    BMSA_READ = 3'h1,
    BMSA_EXEC = 3'h3,
    BMSA_WRITE = 3'h2,
    BMSA_DONE = 3'h6,
    BMSA_ACK = 3'h7
  } bmsa_st_t;
  // Flag bit positions
  localparam int BMSA_F_CARRY = 0;
  localparam int BMSA_F_ZERO = 6;
  // Reset values
  localparam logic [7:0] BMSA_RST_BYTE = 8'h00;
  localparam logic [15:0] BMSA_RST_WORD = 16'h0000;
  // Interrupt acknowledge wait states added to the fetch
  localparam logic [1:0] BMSA_ACK_WAITS = 2'h2;
  // Shortest reset pulse in clocks expected from outside
  localparam int BMSA_RST_MIN_CLK = 3;
endpackage : bmsa_pkg

// *** bmsa_core.sv ***
// Block copy, block compare and 8-bit ALU execution core
// Function
// - Copy up writes source byte, pointers up, count down
// - Copy down moves byte, all three pairs decrement
// - Repeating copy continues until count is zero
// - Compare up subtracts byte, source up, count down
// - Compare down subtracts byte, source and count down
// - Repeating compare stops on zero count or match
// - Compare changes zero flag only, accumulator untouched
// - Add, adc, sub, sbb results go to accumulator
// - And, or, xor results go to accumulator
// - Operand from register, immediate, pointer, index+disp
// - Wait and interrupt request pins synchronised internally
// - Interrupt acknowledge fetch uses io request, two waits
`timescale 1ns/1ps
module bmsa_core (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Command port, same clock domain
  input wire bmsa_pkg::bmsa_cmd_t cmd,
  input wire logic cmd_valid,
  // Register preload, same clock domain
  input wire logic load_en,
  input wire logic [7:0] load_acc,
  input wire logic [15:0] load_src,
  input wire logic [15:0] load_dst,
  input wire logic [15:0] load_cnt,
  input wire logic [15:0] load_ix,
  input wire logic [15:0] load_iy,
  input wire logic [63:0] load_gpr,
  // External bus
  input wire logic [7:0] bus_din,
  input wire logic bus_wait_n,
  input wire logic int_req_n,
  output logic [15:0] bus_addr,
  output logic [7:0] bus_dout,
  output logic bus_doe,
  output bmsa_pkg::bmsa_bus_t bus_ctl,
  // State view
  output logic busy,
  output logic done,
  output logic [7:0] acc_out,
  output logic [7:0] flags_out,
  output logic [15:0] src_out,
  output logic [15:0] dst_out,
  output logic [15:0] cnt_out,
  output logic [7:0] ivec_out
);
  import bmsa_pkg::*;

  // Registers
  bmsa_st_t st_r;
  bmsa_cmd_t cmd_r;
  logic [7:0] acc_r;
  logic [7:0] flags_r;
  logic [15:0] src_r;
  logic [15:0] dst_r;
  logic [15:0] cnt_r;
  logic [15:0] ix_r;
  logic [15:0] iy_r;
  logic [7:0] gpr_r [8];
  logic [7:0] data_r;
  logic [1:0] wait_r;
  logic done_r;
  logic [7:0] ivec_r;
  // Synchronisers for pin controls
  logic [1:0] wait_sync_r;
  logic [1:0] int_sync_r;
  logic wait_s;
  logic int_s;
  // Output registers
  logic [15:0] addr_r;
  logic [7:0] dout_r;
  logic doe_r;
  bmsa_bus_t ctl_r;

  // Arithmetic helper: 9-bit add with carry-in
  function automatic logic [8:0] add9(input logic [7:0] a,
                                      input logic [7:0] b,
                                      input logic ci);
    add9 = {1'b0, a} + {1'b0, b} + {8'h00, ci};
  endfunction : add9

  // Arithmetic helper: 9-bit subtract with borrow, bit 8 is borrow
  function automatic logic [8:0] sub9(input logic [7:0] a,
                                      input logic [7:0] b,
                                      input logic bi);
    sub9 = {1'b0, a} - {1'b0, b} - {8'h00, bi};
  endfunction : sub9

  // Two-flop synchronisers; first stage read only by second
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wait_sync_r <= 2'h3;
      int_sync_r <= 2'h3;
    end else begin
      wait_sync_r <= {wait_sync_r[0], bus_wait_n};
      int_sync_r <= {int_sync_r[0], int_req_n};
    end
  end
  assign wait_s = ~wait_sync_r[1];
  assign int_s = ~int_sync_r[1];

  // Operand address chosen from pointer or index plus displacement
  logic [15:0] op_addr;
  logic [15:0] idx_base;
  always_comb begin
    idx_base = cmd_r.idx_sel ? iy_r : ix_r;
    op_addr = src_r;
    if (cmd_r.src == BMSA_SRC_IDX) begin
      // Signed displacement, sign extended
      op_addr = idx_base + {{8{cmd_r.disp[7]}}, cmd_r.disp};
    end
  end

  // Whether the current command needs a memory read
  logic need_rd;
  logic is_copy;
  logic is_cmp;
  logic is_rep;
  logic step_dn;
  always_comb begin
    is_copy = cmd_r.op inside {BMSA_OP_CPY_UP, BMSA_OP_CPY_DN,
                               BMSA_OP_CPY_RUP, BMSA_OP_CPY_RDN};
    is_cmp = cmd_r.op inside {BMSA_OP_CMP_UP, BMSA_OP_CMP_DN,
                              BMSA_OP_CMP_RUP, BMSA_OP_CMP_RDN};
    is_rep = cmd_r.op inside {BMSA_OP_CMP_RUP, BMSA_OP_CMP_RDN,
                              BMSA_OP_CPY_RUP, BMSA_OP_CPY_RDN};
    step_dn = cmd_r.op inside {BMSA_OP_CMP_DN, BMSA_OP_CMP_RDN,
                               BMSA_OP_CPY_DN, BMSA_OP_CPY_RDN};
    need_rd = is_copy || is_cmp ||
              cmd_r.src inside {BMSA_SRC_PTR, BMSA_SRC_IDX};
  end

  // Source operand value
  logic [7:0] operand;
  always_comb begin
    case (cmd_r.src)
      BMSA_SRC_REG: operand = gpr_r[cmd_r.reg_sel];
      BMSA_SRC_IMM: operand = cmd_r.imm;
      default: operand = data_r;
    endcase
  end

  // ALU result; carry-in is the flag held before the instruction
  logic [8:0] alu_res;
  logic alu_wr_acc;
  logic alu_wr_cy;
  always_comb begin
    alu_wr_acc = 1'b1;
    alu_wr_cy = 1'b1;
    case (cmd_r.op)
      BMSA_OP_ADD: alu_res = add9(acc_r, operand, 1'b0);
      BMSA_OP_ADC: alu_res = add9(acc_r, operand,
                                  flags_r[BMSA_F_CARRY]);
      BMSA_OP_SUB: alu_res = sub9(acc_r, operand, 1'b0);
      BMSA_OP_SBB: alu_res = sub9(acc_r, operand,
                                  flags_r[BMSA_F_CARRY]);
      BMSA_OP_AND: begin
        alu_res = {1'b0, acc_r & operand};
        alu_wr_cy = 1'b0;
      end
      BMSA_OP_OR: begin
        alu_res = {1'b0, acc_r | operand};
        alu_wr_cy = 1'b0;
      end
      BMSA_OP_XOR: begin
        alu_res = {1'b0, acc_r ^ operand};
        alu_wr_cy = 1'b0;
      end
      default: begin
        // Compares keep the accumulator; copies touch no flags
        alu_res = sub9(acc_r, data_r, 1'b0);
        alu_wr_acc = 1'b0;
        alu_wr_cy = 1'b0;
      end
    endcase
  end

  // Next pointer and count values for one block step
  logic [15:0] src_nxt;
  logic [15:0] dst_nxt;
  logic [15:0] cnt_nxt;
  logic match;
  logic again;
  always_comb begin
    src_nxt = step_dn ? src_r - 16'h0001 : src_r + 16'h0001;
    dst_nxt = step_dn ? dst_r - 16'h0001 : dst_r + 16'h0001;
    cnt_nxt = cnt_r - 16'h0001;
    match = (acc_r == data_r);
    // Repeat while count stays nonzero and, for compares, no match
    again = is_rep && (cnt_nxt != BMSA_RST_WORD) &&
            !(is_cmp && match);
  end

  // Last cycle of a command; the state goes back to idle next
  logic st_leave;
  logic busy_r; // Registered busy, follows the next state
  assign st_leave = (st_r == BMSA_DONE && !again) ||
                    (st_r == BMSA_ACK && wait_r == 2'h0 && !wait_s);

  // Sequencer
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_r <= BMSA_IDLE;
      cmd_r <= '0;
      wait_r <= 2'h0;
    end else begin
      case (st_r)
        BMSA_IDLE: begin
          if (cmd_valid) begin
            cmd_r <= cmd;
            if (cmd.op == BMSA_OP_INTA) begin
              st_r <= BMSA_ACK;
              wait_r <= BMSA_ACK_WAITS;
            end else begin
              st_r <= BMSA_READ;
            end
          end
        end
        BMSA_READ: begin
          // External wait stretches the read
          // Strobe is registered, so data is valid one cycle later
          if (!need_rd || (ctl_r.rd && !wait_s)) begin
            st_r <= BMSA_EXEC;
          end
        end
        BMSA_EXEC: st_r <= is_copy ? BMSA_WRITE : BMSA_DONE;
        BMSA_WRITE: begin
          if (!wait_s) begin
            st_r <= BMSA_DONE;
          end
        end
        BMSA_DONE: st_r <= again ? BMSA_READ : BMSA_IDLE;
        BMSA_ACK: begin
          // Two automatic waits, then any external wait
          if (wait_r != 2'h0) begin
            wait_r <= wait_r - 2'h1;
          end else if (!wait_s) begin
            st_r <= BMSA_IDLE;
          end
        end
        default: st_r <= BMSA_IDLE;
      endcase
    end
  end

  // Data capture from the bus, only in read and acknowledge cycles
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      data_r <= BMSA_RST_BYTE;
      ivec_r <= BMSA_RST_BYTE;
    end else begin
      if (st_r == BMSA_READ && need_rd && ctl_r.rd && !wait_s) begin
        data_r <= bus_din;
      end
      if (st_r == BMSA_ACK && wait_r == 2'h0 && !wait_s) begin
        ivec_r <= bus_din;
      end
    end
  end

  // Accumulator and flags
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      acc_r <= BMSA_RST_BYTE;
      flags_r <= BMSA_RST_BYTE;
    end else if (load_en && st_r == BMSA_IDLE) begin
      acc_r <= load_acc;
    end else if (st_r == BMSA_EXEC && !is_copy) begin
      if (alu_wr_acc) begin
        acc_r <= alu_res[7:0];
      end
      if (alu_wr_cy) begin
        flags_r[BMSA_F_CARRY] <= alu_res[8];
      end
      flags_r[BMSA_F_ZERO] <= (alu_res[7:0] == BMSA_RST_BYTE);
    end
  end

  // Pointer pairs, count and general registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      src_r <= BMSA_RST_WORD;
      dst_r <= BMSA_RST_WORD;
      cnt_r <= BMSA_RST_WORD;
      ix_r <= BMSA_RST_WORD;
      iy_r <= BMSA_RST_WORD;
      for (int i = 0; i < 8; i++) begin
        gpr_r[i] <= BMSA_RST_BYTE;
      end
    end else if (load_en && st_r == BMSA_IDLE) begin
      src_r <= load_src;
      dst_r <= load_dst;
      cnt_r <= load_cnt;
      ix_r <= load_ix;
      iy_r <= load_iy;
      for (int i = 0; i < 8; i++) begin
        gpr_r[i] <= load_gpr[i*8 +: 8];
      end
    end else if (st_r == BMSA_DONE && (is_copy || is_cmp)) begin
      src_r <= src_nxt;
      cnt_r <= cnt_nxt;
      if (is_copy) begin
        dst_r <= dst_nxt;
      end
    end
  end

  // Registered bus outputs
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      addr_r <= BMSA_RST_WORD;
      dout_r <= BMSA_RST_BYTE;
      doe_r <= 1'b0;
      ctl_r <= '0;
      done_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      done_r <= st_leave;
      // Idle takes a valid command; otherwise busy until leaving
      busy_r <= (st_r == BMSA_IDLE) ? cmd_valid : !st_leave;
      ctl_r <= '0;
      doe_r <= 1'b0;
      if (st_r == BMSA_READ && need_rd) begin
        addr_r <= op_addr;
        ctl_r.mreq <= 1'b1;
        ctl_r.rd <= 1'b1;
      end else if (st_r == BMSA_EXEC && is_copy) begin
        addr_r <= dst_r;
        dout_r <= data_r;
        doe_r <= 1'b1;
        ctl_r.mreq <= 1'b1;
        ctl_r.wr <= 1'b1;
      end else if (st_r == BMSA_WRITE && wait_s) begin
        doe_r <= 1'b1;
        ctl_r.mreq <= 1'b1;
        ctl_r.wr <= 1'b1;
      end else if (st_r == BMSA_ACK) begin
        // Acknowledge fetch uses io request in place of mreq
        ctl_r.fetch <= 1'b1;
        ctl_r.io_request <= 1'b1;
      end
    end
  end

  // Outputs straight from flip-flops
  assign bus_addr = addr_r;
  assign bus_dout = dout_r;
  assign bus_doe = doe_r;
  assign bus_ctl = ctl_r;
  assign busy = busy_r;
  assign done = done_r;
  assign acc_out = acc_r;
  assign flags_out = flags_r;
  assign src_out = src_r;
  assign dst_out = dst_r;
  assign cnt_out = cnt_r;
  assign ivec_out = ivec_r;

  // Compare never alters accumulator
  AST_CMP_KEEPS_ACC: assert property (
    @(posedge sys_clk) disable iff (rst)
    (st_r == BMSA_EXEC && is_cmp) |=> $stable(acc_r))
    else $error("compare changed accumulator");
  // Count drops by one per block step
  AST_CNT_STEP: assert property (
    @(posedge sys_clk) disable iff (rst)
    (st_r == BMSA_DONE && (is_copy || is_cmp)) |=>
    cnt_r == $past(cnt_r) - 16'h0001)
    else $error("count step wrong");
  // Repeat stops at zero count
  AST_REP_ZERO: assert property (
    @(posedge sys_clk) disable iff (rst)
    (st_r == BMSA_DONE && is_rep && cnt_nxt == 16'h0000) |=>
    st_r == BMSA_IDLE)
    else $error("repeat passed zero count");
  // Compare repeat stops on match
  AST_CMP_MATCH: assert property (
    @(posedge sys_clk) disable iff (rst)
    (st_r == BMSA_DONE && is_rep && is_cmp && match) |=>
    st_r == BMSA_IDLE)
    else $error("search continued after match");
  // Acknowledge holds two waits with io request
  AST_ACK_WAITS: assert property (
    @(posedge sys_clk) disable iff (rst)
    ($rose(st_r == BMSA_ACK)) |=> (bus_ctl.io_request && !bus_ctl.mreq) [*2])
    else $error("acknowledge waits missing");
  // Zero flag mirrors compare equality
  AST_ZERO_FLAG: assert property (
    @(posedge sys_clk) disable iff (rst)
    (st_r == BMSA_EXEC && is_cmp) |=>
    flags_out[BMSA_F_ZERO] == (acc_r == data_r))
    else $error("zero flag wrong");
  // Copy write drives destination address
  AST_COPY_ADDR: assert property (
    @(posedge sys_clk) disable iff (rst)
    (st_r == BMSA_EXEC && is_copy) |=>
    bus_ctl.wr && bus_addr == dst_r && bus_dout == data_r)
    else $error("copy write wrong");
  // Add with carry uses the previous carry
  AST_ADC: assert property (
    @(posedge sys_clk) disable iff (rst)
    (st_r == BMSA_EXEC && cmd_r.op == BMSA_OP_ADC) |=>
    acc_r == $past(acc_r) + $past(operand) +
    {7'h00, $past(flags_r[BMSA_F_CARRY])})
    else $error("add with carry wrong");
  // Read data is only taken while the read strobe stands
  AST_READ_STROBE: assert property (
    @(posedge sys_clk) disable iff (rst)
    ($rose(st_r == BMSA_EXEC) && need_rd) |-> $past(bus_ctl.rd))
    else $error("read data taken without strobe");
endmodule : bmsa_core

// *** bmsa_mem_model.sv ***
// Memory and I/O partner model facing the block datapath bus
`timescale 1ns/1ps
module bmsa_mem_model (
  // Clock and test controls
  input wire logic sys_clk,
  input wire logic slow,
  input wire logic [7:0] vec,
  // Bus from the core
  input wire logic [15:0] bus_addr,
  input wire logic [7:0] bus_dout,
  input wire logic bus_doe,
  input wire bmsa_pkg::bmsa_bus_t bus_ctl,
  // Answers to the core
  output logic [7:0] bus_din,
  output logic bus_wait_n
);
  import bmsa_pkg::*;
  logic [7:0] mem [0:65535]; // Whole address space
  logic [7:0] last_r = 8'h00; // Last value seen on the line
  logic [1:0] age_r = 2'h0; // Cycles into the current strobe
  logic act; // Any access strobe up
  assign act = bus_ctl.rd | bus_ctl.wr | bus_ctl.io_request;
  // Slow mode: two wait cycles at the head of every access
  assign bus_wait_n = !(slow && act && age_r < 2'h2);
  // Strobe age, write capture and released-line history
  always @(posedge sys_clk) begin
    age_r <= !act ? 2'h0 : (age_r == 2'h3) ? age_r : age_r + 2'h1;
    if (bus_ctl.wr && bus_ctl.mreq && bus_doe) begin
      mem[bus_addr] <= bus_dout;
    end
    last_r <= bus_din;
  end
  // Released line toggles so a stale byte never looks valid
  always_comb begin
    if (bus_ctl.fetch && bus_ctl.io_request) begin
      bus_din = vec;
    end else if (bus_ctl.rd && bus_ctl.mreq) begin
      bus_din = mem[bus_addr];
    end else begin
      bus_din = ~last_r;
    end
  end
endmodule : bmsa_mem_model

// *** block_move_search_alu_tb.sv ***
// Self-checking bench for the block move, search and ALU core
`timescale 1ns/1ps
module block_move_search_alu_tb;
  import bmsa_pkg::*;
  // Design inputs
  logic sys_clk = 1'h0, rst = 1'h1, cmd_valid = 1'h0, load_en = 1'h0;
  bmsa_cmd_t cmd = '0;
  logic [7:0] load_acc = 8'h00, bus_din;
  logic [15:0] load_src = 16'h0, load_dst = 16'h0, load_cnt = 16'h0;
  logic [15:0] load_ix = 16'h0, load_iy = 16'h0;
  logic [63:0] load_gpr = 64'h0;
  logic bus_wait_n, int_req_n = 1'h1, slow = 1'h0, bus_doe, busy, done;
  // Design outputs
  bmsa_bus_t bus_ctl;
  logic [7:0] vec = 8'h00, bus_dout, acc_out, flags_out, ivec_out, a, b;
  logic [7:0] imm, disp, ex [8];
  logic [15:0] bus_addr, src_out, dst_out, cnt_out, s, d;
  logic [8:0] r;
  logic up, c;
  int fails = 0, cmp_count = 0, ack_cyc = 0, mix_cyc = 0, n, m, st;
  bmsa_op_t op;
  bmsa_op_t cops [4] = '{BMSA_OP_CMP_UP, BMSA_OP_CMP_DN,
                         BMSA_OP_CMP_RUP, BMSA_OP_CMP_RDN};
  bmsa_op_t kops [4] = '{BMSA_OP_CPY_UP, BMSA_OP_CPY_DN,
                         BMSA_OP_CPY_RUP, BMSA_OP_CPY_RDN};
  bmsa_core dut (.sys_clk(sys_clk), .rst(rst), .cmd(cmd),
    .cmd_valid(cmd_valid), .load_en(load_en), .load_acc(load_acc),
    .load_src(load_src), .load_dst(load_dst), .load_cnt(load_cnt),
    .load_ix(load_ix), .load_iy(load_iy), .load_gpr(load_gpr),
    .bus_din(bus_din), .bus_wait_n(bus_wait_n), .int_req_n(int_req_n),
    .bus_addr(bus_addr), .bus_dout(bus_dout), .bus_doe(bus_doe),
    .bus_ctl(bus_ctl), .busy(busy), .done(done), .acc_out(acc_out),
    .flags_out(flags_out), .src_out(src_out), .dst_out(dst_out),
    .cnt_out(cnt_out), .ivec_out(ivec_out));
  bmsa_mem_model mdl (.sys_clk(sys_clk), .slow(slow), .vec(vec),
    .bus_addr(bus_addr), .bus_dout(bus_dout), .bus_doe(bus_doe),
    .bus_ctl(bus_ctl), .bus_din(bus_din), .bus_wait_n(bus_wait_n));
  // 125 MHz clock
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end
  // Interrupt line wanders freely; the core only observes it
  always @(posedge sys_clk) begin
    #1 int_req_n = 1'($urandom_range(1));
  end
  // Acknowledge cycle count and memory/io overlap watch
  always @(posedge sys_clk) begin
    if (bus_ctl.io_request === 1'h1 && bus_ctl.fetch === 1'h1) ack_cyc++;
    if (bus_ctl.io_request === 1'h1 && bus_ctl.mreq === 1'h1) mix_cyc++;
  end
  // Hang guard, well beyond the expected run
  initial begin
    #(8 * 20000);
    fails++;
    $display("wrong value at %0t: watchdog expired", $time);
    tally_and_finish();
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [15:0] got, exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  // Inputs always move 1 ns after the rising edge
  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask : tick
  // Preload; the trailing idle cycle keeps strobes from doubling
  task automatic load(input logic [7:0] la, input logic [15:0] ls, ld, lc);
    cmd_valid = 1'h0;
    load_acc = la;
    load_src = ls;
    load_dst = ld;
    load_cnt = lc;
    load_en = 1'h1;
    tick();
    load_en = 1'h0;
    tick();
  endtask : load
  // Valid stays up while busy, so the core must refuse repeats
  task automatic run(input bmsa_op_t o, input bmsa_src_t sk,
                     input logic [2:0] rs, input logic [7:0] im, dp,
                     input logic isel);
    cmd = '{o, sk, isel, rs, im, dp};
    cmd_valid = 1'h1;
    repeat (3000) begin
      tick();
      if (done === 1'h1) break;
    end
    chk(done, 16'h1, "done pulse");
    chk(busy, 16'h0, "busy after done");
  endtask : run
  function automatic logic [8:0] alu(bmsa_op_t o, logic [7:0] x, y,
                                     logic ci);
    case (o)
      BMSA_OP_ADD: return {1'h0, x} + {1'h0, y};
      BMSA_OP_ADC: return {1'h0, x} + {1'h0, y} + {8'h00, ci};
      BMSA_OP_SUB: return {1'h0, x} - {1'h0, y};
      BMSA_OP_SBB: return {1'h0, x} - {1'h0, y} - {8'h00, ci};
      BMSA_OP_AND: return {ci, x & y};
      BMSA_OP_OR: return {ci, x | y};
      default: return {ci, x ^ y};
    endcase
  endfunction : alu
  function automatic logic [7:0] opnd(bmsa_src_t sk, logic [2:0] rs,
                                      logic [7:0] im, dp, logic isel);
    logic [15:0] ea;
    ea = (isel ? load_iy : load_ix) + {{8{dp[7]}}, dp};
    case (sk)
      BMSA_SRC_REG: return load_gpr[8 * rs +: 8];
      BMSA_SRC_IMM: return im;
      BMSA_SRC_PTR: return mdl.mem[load_src];
      default: return mdl.mem[ea];
    endcase
  endfunction : opnd
  function automatic logic [15:0] at(logic [15:0] p, int j, logic u);
    return u ? p + 16'(j) : p - 16'(j);
  endfunction : at
  task automatic chk_acc(input logic [8:0] e);
    chk(acc_out, e[7:0], "acc");
    chk({flags_out[BMSA_F_ZERO], flags_out[BMSA_F_CARRY]},
        {e[7:0] == 8'h00, e[8]}, "flags");
  endtask : chk_acc
  // Main sequence
  initial begin
    void'($urandom(75));
    load_gpr = {$urandom(), $urandom()};
    load_ix = {8'h50, 8'($urandom())};
    load_iy = {8'h60, 8'($urandom())};
    for (int i = 0; i < 65536; i++) mdl.mem[i] = 8'($urandom());
    repeat (16) tick();
    rst = 1'h0;
    chk({busy, acc_out}, 16'h0, "after reset");
    chk(flags_out, 16'h0, "flags after reset");
    // ALU ops over every source kind, carry set up by an add
    for (int i = 0; i < 56; i++) begin
      op = bmsa_op_t'(i % 7);
      a = (i == 0) ? 8'hff : 8'($urandom());
      imm = (i == 0) ? 8'h01 : 8'($urandom());
      load(a, 16'($urandom()), 16'h0, 16'h0);
      run(BMSA_OP_ADD, BMSA_SRC_IMM, 3'h0, imm, 8'h00, 1'h0);
      r = alu(BMSA_OP_ADD, a, imm, 1'h0);
      chk_acc(r);
      imm = 8'($urandom());
      disp = 8'($urandom());
      b = opnd(bmsa_src_t'(i % 4), 3'(i), imm, disp, i[2]);
      run(op, bmsa_src_t'(i % 4), 3'(i), imm, disp, i[2]);
      chk_acc(alu(op, r[7:0], b, r[8]));
    end
    $display("alu test finished");
    // Compares, with a match anywhere in the run or none at all
    for (int i = 0; i < 16; i++) begin
      up = (i % 2 == 0);
      a = 8'($urandom());
      s = {8'h40, 8'($urandom())};
      n = 1 + $urandom_range(4);
      m = $urandom_range(n);
      for (int j = 0; j < 8; j++) begin
        mdl.mem[at(s, j, up)] = a + 8'(1 + $urandom_range(253));
      end
      if (m < n) mdl.mem[at(s, m, up)] = a;
      st = (i % 4 < 2) ? 1 : ((m < n) ? m + 1 : n);
      load(a, s, 16'h0, 16'(n));
      run(cops[i % 4], BMSA_SRC_PTR, 3'h0, 8'h00, 8'h00, 1'h0);
      chk(acc_out, a, "cmp acc");
      chk(src_out, at(s, st, up), "cmp src");
      chk(cnt_out, 16'(n - st), "cmp cnt");
      chk(flags_out[BMSA_F_ZERO], (i % 4 < 2) ? m == 0 : m < n,
          "cmp zero");
    end
    $display("compare test finished");
    // Copies, pointer wrap corners first, slow memory later
    for (int i = 0; i < 8; i++) begin
      up = (i % 2 == 0);
      slow = (i >= 4);
      s = (i == 0) ? 16'hffff : {8'h10, 8'($urandom())};
      d = (i == 1) ? 16'h0000 : {8'h30, 8'($urandom())};
      n = 1 + $urandom_range(4);
      st = (i % 4 < 2) ? 1 : n;
      for (int j = 0; j < 8; j++) begin
        ex[j] = 8'($urandom());
        mdl.mem[at(s, j, up)] = ex[j];
        mdl.mem[at(d, j, up)] = ~ex[j];
      end
      load(8'h00, s, d, 16'(n));
      run(kops[i % 4], BMSA_SRC_PTR, 3'h0, 8'h00, 8'h00, 1'h0);
      for (int j = 0; j <= st; j++) begin
        chk(mdl.mem[at(d, j, up)], (j < st) ? ex[j] : 8'(~ex[j]),
            "copy byte");
      end
      chk(src_out, at(s, st, up), "copy src");
      chk(dst_out, at(d, st, up), "copy dst");
      chk(cnt_out, 16'(n - st), "copy cnt");
    end
    slow = 1'h0;
    $display("copy test finished");
    // Reset in mid copy, shortest pulse, then an instant command
    load(8'h5a, 16'h1200, 16'h3400, 16'h0005);
    cmd = '{BMSA_OP_CPY_RUP, BMSA_SRC_PTR, 1'h0, 3'h0, 8'h00, 8'h00};
    cmd_valid = 1'h1;
    repeat (3) tick();
    rst = 1'h1;
    cmd_valid = 1'h0;
    repeat (3) tick();
    chk({busy, acc_out, bus_ctl}, 16'h0, "in reset");
    chk(cnt_out, 16'h0, "cnt in reset");
    rst = 1'h0;
    imm = 8'($urandom());
    run(BMSA_OP_ADD, BMSA_SRC_IMM, 3'h0, imm, 8'h00, 1'h0);
    chk_acc(alu(BMSA_OP_ADD, 8'h00, imm, 1'h0));
    $display("reset test finished");
    // Interrupt acknowledge fetch
    vec = 8'($urandom());
    load(8'h00, 16'h0, 16'h0, 16'h0);
    ack_cyc = 0;
    run(BMSA_OP_INTA, BMSA_SRC_REG, 3'h0, 8'h00, 8'h00, 1'h0);
    // Last io strobe cycle is sampled one edge after done
    cmd_valid = 1'h0;
    tick();
    chk(ivec_out, vec, "vector");
    chk(16'(ack_cyc), 16'h0003, "ack cycles");
    chk(16'(mix_cyc), 16'h0000, "mreq with io_request");
    $display("acknowledge test finished");
    tally_and_finish();
  end
endmodule : block_move_search_alu_tb
